/* File: common/flash_host_pkg.sv */
package flash_host_pkg;
	// bios window on the cpu bus
	localparam logic [19:0] bios_lo_addr      = 20'hE0000;
	localparam logic [19:0] bios_hi_addr      = 20'hFFFFF;
	// command sequence addresses and codes
	localparam logic [16:0] unlock1_addr      = 17'h05555;
	localparam logic [16:0] unlock2_addr      = 17'h02AAA;
	localparam logic [16:0] ident_addr        = 17'h00000;
	localparam logic [7:0]  unlock1_data      = 8'hAA;
	localparam logic [7:0]  unlock2_data      = 8'h55;
	localparam logic [7:0]  ident_cmd         = 8'h90;
	localparam logic [7:0]  reset_cmd         = 8'hF0;
	localparam logic [7:0]  program_cmd       = 8'hA0;
	// status bit positions
	localparam int          poll_bit_seven    = 7;
	localparam int          toggle_bit_six    = 6;
	localparam int          timeout_bit_five  = 5;
	localparam int          failure_kind_bit  = 4;
	// sector index position in the flash address
	localparam int          sector_index_low  = 14;
	// bus timing: strobe low and gap, in ns and cycles at 20 MHz
	localparam int          clk_period_ns     = 50;
	localparam int          strobe_ns         = 100;
	localparam int          strobe_cycles     = (strobe_ns + clk_period_ns - 1) / clk_period_ns;
	// operation kinds
	typedef enum logic [1:0] {
		op_ident   = 2'b00,
		op_program = 2'b01,
		op_reset   = 2'b10,
		op_read    = 2'b11
	} op_t;
endpackage : flash_host_pkg

/* File: logic/bios_write_decode.sv */
`timescale 1ns/100ps
// cpu-side glue: flash write strobe and buffer direction
module bios_write_decode
	import flash_host_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// cpu cycle (already synchronised)
	input  wire logic [19:0] cpu_addr,
	input  wire logic        cpu_mem_cycle,
	input  wire logic        cpu_write_cycle,
	input  wire logic        cpu_cycle_active,
	// glue outputs
	output logic             memory_write_strobe_n,
	output logic             buffer_to_flash
);
	// address range and cycle qualification
	wire in_range  = (cpu_addr >= bios_lo_addr) && (cpu_addr <= bios_hi_addr);
	wire qual_wr   = in_range && cpu_mem_cycle && cpu_write_cycle && cpu_cycle_active;
	// registered strobe, high outside qualified writes
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			memory_write_strobe_n <= 1'b1;
			buffer_to_flash       <= 1'b0;
		end else begin
			memory_write_strobe_n <= ~qual_wr;
			buffer_to_flash       <= qual_wr;
		end
	end
endmodule : bios_write_decode

/* File: logic/flash_host.sv */
`timescale 1ns/100ps
// How it works
// - strobe decoded from bios range, memory, write, active cycle
// - buffer turns toward flash only on qualified bios writes
// - identify: aa, 55, 90 then read 0000
// - recheck bit seven after timeout bit set
// - recheck toggle bit six after timeout set
module flash_host
	import flash_host_pkg::*;
#(
	parameter int poll_limit = 65535
)(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// cpu bus cycle pins
	input  wire logic [19:0] cpu_addr,
	input  wire logic        cpu_mem_cycle,
	input  wire logic        cpu_write_cycle,
	input  wire logic        cpu_cycle_active,
	// user command port
	input  wire logic        cmd_valid,
	input  wire logic [1:0]  cmd_op,
	input  wire logic [16:0] cmd_addr,
	input  wire logic [7:0]  cmd_data,
	output logic             cmd_ready,
	output logic             rsp_valid,
	output logic [7:0]       rsp_data,
	output logic             rsp_fail,
	output logic [2:0]       rsp_sector,
	// flash pins
	output logic [16:0]      flash_addr,
	output logic             flash_ce_n,
	output logic             flash_oe_n,
	output logic             flash_we_n,
	input  wire logic [7:0]  flash_dq_in,
	output logic [7:0]       flash_dq_out,
	output logic             flash_dq_oe_n,
	// board glue
	output logic             memory_write_strobe_n,
	output logic             buffer_to_flash
);
	typedef enum logic [3:0] {
		st_idle  = 4'b0000,
		st_wr    = 4'b0001,
		st_wgap  = 4'b0010,
		st_rd    = 4'b0011,
		st_poll  = 4'b0100,
		st_check = 4'b0101,
		st_recheck = 4'b0110,
		st_done  = 4'b0111
	} state_t;

	state_t      state_r, state_nxt;
	logic [2:0]  step_r;
	logic [1:0]  op_r;
	logic [16:0] addr_r;
	logic [7:0]  data_r;
	logic [1:0]  cnt_r;
	logic [15:0] poll_cnt_r;
	logic [7:0]  dq_s1_r, dq_s2_r, prev_r;
	logic [19:0] a_s1_r, a_s2_r;
	logic [2:0]  c_s1_r, c_s2_r;
	logic        fail_r;
	logic        timeout_seen_r;

	// cpu pins and flash data through two flops
	always_ff @(posedge sys_clk) begin
		dq_s1_r <= flash_dq_in;
		dq_s2_r <= dq_s1_r;
		a_s1_r  <= cpu_addr;
		a_s2_r  <= a_s1_r;
		c_s1_r  <= {cpu_mem_cycle, cpu_write_cycle, cpu_cycle_active};
		c_s2_r  <= c_s1_r;
	end

	// board glue decode
	bios_write_decode u_decode (
		.sys_clk               (sys_clk),
		.reset                 (reset),
		.cpu_addr              (a_s2_r),
		.cpu_mem_cycle         (c_s2_r[2]),
		.cpu_write_cycle       (c_s2_r[1]),
		.cpu_cycle_active      (c_s2_r[0]),
		.memory_write_strobe_n (memory_write_strobe_n),
		.buffer_to_flash       (buffer_to_flash)
	);

	// address and data of the current write step
	function automatic logic [16:0] step_addr(input logic [2:0] s, input logic [16:0] a);
		unique case (s)
			3'd0: step_addr = unlock1_addr;
			3'd1: step_addr = unlock2_addr;
			3'd2: step_addr = unlock1_addr;
			default: step_addr = a;
		endcase
	endfunction : step_addr

	function automatic logic [7:0] step_data(input logic [2:0] s, input logic [1:0] o,
	                                         input logic [7:0] d);
		logic [7:0] cmd;
		cmd = (o == op_ident) ? ident_cmd : (o == op_program) ? program_cmd : reset_cmd;
		unique case (s)
			3'd0: step_data = unlock1_data;
			3'd1: step_data = unlock2_data;
			3'd2: step_data = cmd;
			default: step_data = d;
		endcase
	endfunction : step_data

	// status decode of a polled read
	wire       bit7_done  = dq_s2_r[poll_bit_seven] == data_r[poll_bit_seven];
	wire       toggling   = dq_s2_r[toggle_bit_six] != prev_r[toggle_bit_six];
	wire       timed_out  = dq_s2_r[timeout_bit_five];
	wire       last_write = (op_r == op_program) ? (step_r == 3'd3) : (step_r == 3'd2);
	wire       strobe_end = (cnt_r == 2'(strobe_cycles - 1));
	wire       poll_over  = (poll_cnt_r == 16'(poll_limit));
	wire       op_ok      = bit7_done && !toggling;
	wire       give_up    = (timed_out || poll_over) && (op_r == op_program);
	wire       retry_rst  = fail_r && (op_r == op_program);
	// the synchronised byte of a read lands two edges late, so a check decides in its last cycle
	state_t    check_next;
	assign check_next = (op_r != op_program || op_ok || timeout_seen_r) ? st_done :
	                    give_up ? st_recheck : st_poll;

	// next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			st_idle:    if (cmd_valid) state_nxt = (cmd_op == op_read) ? st_rd : st_wr;
			st_wr:      if (strobe_end) state_nxt = st_wgap;
			st_wgap:    if (strobe_end) state_nxt = !last_write ? st_wr :
			                (op_r == op_ident) ? st_rd :
			                (op_r == op_program) ? st_poll : st_done;
			st_rd:      if (strobe_end) state_nxt = st_check;
			st_poll:    if (strobe_end) state_nxt = st_check;
			st_check:   if (strobe_end) state_nxt = check_next;
			st_recheck: if (strobe_end) state_nxt = st_check;
			st_done:    state_nxt = retry_rst ? st_wr : st_idle;
		endcase
	end

	// sequencer registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r        <= st_idle;
			step_r         <= 3'd0;
			op_r           <= op_read;
			addr_r         <= '0;
			data_r         <= '0;
			cnt_r          <= '0;
			poll_cnt_r     <= '0;
			prev_r         <= '0;
			fail_r         <= 1'b0;
			timeout_seen_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= (state_nxt != state_r) ? 2'd0 : cnt_r + 2'd1;
			if (state_r == st_idle && cmd_valid) begin
				op_r       <= cmd_op;
				addr_r     <= (cmd_op == op_ident) ? ident_addr : cmd_addr;
				data_r     <= cmd_data;
				step_r     <= 3'd0;
				poll_cnt_r <= '0;
				fail_r     <= 1'b0;
				timeout_seen_r <= 1'b0;
			end
			if (state_r == st_wgap && strobe_end)
				step_r <= step_r + 3'd1;
			if (state_r == st_check && strobe_end) begin
				prev_r     <= dq_s2_r;
				poll_cnt_r <= poll_cnt_r + 16'd1;
				if (give_up)
					timeout_seen_r <= 1'b1;
				// after a timeout, the extra read decides the outcome
				if (timeout_seen_r && !op_ok && op_r == op_program)
					fail_r <= 1'b1;
			end
			// a failed operation is followed by the reset sequence
			if (state_r == st_done && retry_rst) begin
				op_r   <= op_reset;
				step_r <= 3'd0;
			end
		end
	end

	// flash pin drive
	wire in_wr   = (state_r == st_wr);
	wire in_rd   = (state_r == st_rd) || (state_r == st_poll) || (state_r == st_recheck);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flash_addr    <= '0;
			flash_ce_n    <= 1'b1;
			flash_oe_n    <= 1'b1;
			flash_we_n    <= 1'b1;
			flash_dq_out  <= '0;
			flash_dq_oe_n <= 1'b1;
			cmd_ready     <= 1'b0;
			rsp_valid     <= 1'b0;
			rsp_data      <= '0;
			rsp_fail      <= 1'b0;
			rsp_sector    <= '0;
		end else begin
			flash_addr    <= (in_wr || state_r == st_wgap) ? step_addr(step_r, addr_r) : addr_r;
			flash_ce_n    <= !(in_wr || in_rd);
			flash_oe_n    <= !in_rd;
			flash_we_n    <= !in_wr;
			flash_dq_out  <= step_data(step_r, op_r, data_r);
			flash_dq_oe_n <= !(in_wr || state_r == st_wgap);
			cmd_ready     <= (state_nxt == st_idle);
			rsp_valid     <= (state_r == st_done) && !(fail_r && op_r == op_program);
			if (state_r == st_check && strobe_end)
				rsp_data <= dq_s2_r;
			rsp_fail      <= (state_r == st_done) ? (fail_r || timeout_seen_r) & fail_r
			                 : rsp_fail & ~cmd_valid;
			rsp_sector    <= addr_r[sector_index_low +: 3];
		end
	end
endmodule : flash_host

/* File: sim/flash_host_checker.sv */
`timescale 1ns/100ps
// pin-level checks on the host
module flash_host_checker
	import flash_host_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        reset,
	// cpu cycle and glue
	input wire logic [19:0] cpu_addr,
	input wire logic        cpu_mem_cycle,
	input wire logic        cpu_write_cycle,
	input wire logic        cpu_cycle_active,
	input wire logic        memory_write_strobe_n,
	input wire logic        buffer_to_flash,
	// flash side
	input wire logic        flash_ce_n,
	input wire logic        flash_oe_n,
	input wire logic        flash_we_n,
	input wire logic        flash_dq_oe_n,
	input wire logic        rsp_valid
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// glue strobe and buffer
	chk_strobe_range: assert property (
		!memory_write_strobe_n |-> $past(cpu_addr, 3) >= bios_lo_addr && $past(cpu_write_cycle, 3))
		else $error("strobe outside bios write");
	chk_strobe_qual: assert property (
		!memory_write_strobe_n |-> $past(cpu_mem_cycle, 3) && $past(cpu_cycle_active, 3))
		else $error("strobe on unqualified cycle");
	chk_buf_match: assert property (buffer_to_flash == !memory_write_strobe_n)
		else $error("buffer direction off");
	// flash write pulses, read bus release and response pulse
	chk_we_width: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
		else $error("write pulse width");
	chk_we_gap: assert property ($rose(flash_we_n) |-> flash_we_n ##1 flash_we_n)
		else $error("write gap short");
	chk_we_drive: assert property (!flash_we_n |-> !flash_dq_oe_n && !flash_ce_n)
		else $error("write without data");
	chk_oe_float: assert property (!flash_oe_n |-> flash_dq_oe_n && flash_we_n)
		else $error("read while driving");
	chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
		else $error("response not a pulse");
endmodule : flash_host_checker

bind flash_host flash_host_checker chk_inst (.sys_clk, .reset, .cpu_addr, .cpu_mem_cycle,
	.cpu_write_cycle, .cpu_cycle_active, .memory_write_strobe_n, .buffer_to_flash,
	.flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_oe_n, .rsp_valid);

/* File: sim/flash_model.sv */
`timescale 1ns/100ps
// behavioural flash part on the host pins
module flash_model
	import flash_host_pkg::*;
#(
	parameter logic [7:0] maker_code = 8'h3C, // arbitrary value
	parameter int         busy_reads = 3
)(
	// flash pins
	input wire logic [16:0] addr,
	input wire logic        ce_n,
	input wire logic        oe_n,
	input wire logic        we_n,
	input wire logic [7:0]  din,
	output logic [7:0]      dq,
	// scenario controls
	input wire logic        pwr_ok,
	input wire logic        stuck
);
	logic [7:0] mem [0:131071];
	logic [7:0] q = 8'h00, wd = 8'h00;
	logic [2:0] sector = 3'h0;
	logic       id = 1'b0, tg = 1'b0;
	int         st = 0, busy = 0; // power-up in read mode
	// blank part reads all ones
	initial for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
	// commands on the rising write edge, ignored without supply
	always @(posedge we_n) begin
		if (pwr_ok) begin
			if (st == 3) begin
				mem[addr] = din;
				wd = din;
				sector = addr[16:14];
				busy = busy_reads;
				st = 0;
			end else if (st == 2) begin
				id = (din == ident_cmd);
				st = (din == program_cmd) ? 3 : 0;
				if (din == reset_cmd) busy = 0;
			end else if (din == (st ? unlock2_data : unlock1_data)
				&& addr == (st ? unlock2_addr : unlock1_addr)) begin
				st++;
			end else begin
				st = 0;
			end
		end
	end
	// status while busy, else array or maker code
	always @(negedge oe_n) begin
		#1;
		if (busy > 0) begin
			tg = ~tg;
			q = {~wd[7], tg, stuck, 1'b0, 4'h0};
			if (!stuck) busy--;
		end else begin
			q = id ? maker_code : mem[addr];
		end
	end
	// released bus shows the inverse of the last byte
	assign dq = (!ce_n && !oe_n) ? q : ~q;
endmodule : flash_model

/* File: sim/testbench.sv */
`timescale 1ns/100ps
// bench for the bios flash host
module testbench
	import flash_host_pkg::*;
;
	localparam logic [7:0] maker_code = 8'h3C; // arbitrary value
	logic        sys_clk = 1'b0, reset = 1'b1, stuck = 1'b0, vcc_ok = 1'b0;
	logic [19:0] cpu_addr = 20'h00000;
	logic        cpu_mem_cycle = 1'b0, cpu_write_cycle = 1'b0, cpu_cycle_active = 1'b0;
	logic        cmd_valid = 1'b0, cmd_ready, rsp_valid, rsp_fail;
	logic [1:0]  cmd_op = 2'b00;
	logic [16:0] cmd_addr = 17'h00000, flash_addr;
	logic [7:0]  cmd_data = 8'h00, rsp_data, flash_dq_out, dev_dq, dq_bus;
	logic [2:0]  rsp_sector;
	logic        flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n;
	logic        memory_write_strobe_n, buffer_to_flash;
	int          fail_count = 0, checks_done = 0;
	logic [22:0] cyc [6] = '{{20'hE0000, 3'b111}, {20'hFFFFF, 3'b111}, {20'hDFFFF, 3'b111},
		{20'hF0000, 3'b101}, {20'hF0000, 3'b011}, {20'hF0000, 3'b110}};
	logic [5:0]  strobe_exp = 6'b111100;
	// wire level from both drivers
	assign dq_bus = !flash_dq_oe_n ? flash_dq_out : dev_dq;
	flash_host #(.poll_limit(8)) flash_host_inst (.sys_clk, .reset, .cpu_addr, .cpu_mem_cycle,
		.cpu_write_cycle, .cpu_cycle_active, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data,
		.cmd_ready, .rsp_valid, .rsp_data, .rsp_fail, .rsp_sector, .flash_addr, .flash_ce_n,
		.flash_oe_n, .flash_we_n, .flash_dq_in(dq_bus), .flash_dq_out, .flash_dq_oe_n,
		.memory_write_strobe_n, .buffer_to_flash);
	flash_model #(.maker_code(maker_code)) flash_model_inst (.addr(flash_addr),
		.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .din(dq_bus),
		.dq(dev_dq), .pwr_ok(vcc_ok), .stuck);
	always #25 sys_clk = ~sys_clk;
	// compare one byte
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one command, waits for its response
	task automatic op(input logic [1:0] o, input logic [16:0] a, input logic [7:0] d);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (cmd_ready !== 1'b1 && n < 3000);
		@(posedge sys_clk);
		{cmd_op, cmd_addr, cmd_data, cmd_valid} <= {o, a, d, 1'b1};
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (rsp_valid !== 1'b1 && n < 3000);
		if (n >= 3000) chk(8'h00, 8'h01);
	endtask : op
	// verdict
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	// main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		op(op_ident, 17'h00000, 8'h00);
		chk(rsp_data, 8'hFF);
		vcc_ok <= 1'b1;
		op(op_ident, 17'h00000, 8'h00);
		chk(rsp_data, maker_code);
		op(op_program, 17'h1C123, 8'h5A);
		chk({7'h00, rsp_fail}, 8'h00);
		chk({5'h00, rsp_sector}, 8'h07);
		op(op_read, 17'h1C123, 8'h00);
		chk(rsp_data, 8'h5A);
		stuck <= 1'b1;
		op(op_program, 17'h04000, 8'hA5);
		chk({7'h00, rsp_fail}, 8'h01);
		chk({5'h00, rsp_sector}, 8'h01);
		stuck <= 1'b0;
		op(op_read, 17'h04000, 8'h00);
		chk(rsp_data, 8'hA5);
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			{cpu_addr, cpu_mem_cycle, cpu_write_cycle, cpu_cycle_active} <= cyc[i];
			repeat (5) @(posedge sys_clk);
			#1;
			chk({7'h00, memory_write_strobe_n}, {7'h00, strobe_exp[i]});
			chk({7'h00, buffer_to_flash}, {7'h00, ~strobe_exp[i]});
		end
		end_sim();
	end
	// hang guard
	initial begin
		#500000;
		fail_count++;
		end_sim();
	end
endmodule : testbench
